// *** design/bsrx_config.sv ***
`include "bsrx_defines.svh"

module bsrx_config
  import bsrx_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic       rstn_i,
  input  wire logic [5:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  input  wire logic       rx_enable_i,
  input  wire logic [1:0] bit_valid_i,
  input  wire logic [1:0] bit_data_i,
  input  wire logic       bit_tick_i,
  input  wire logic       tx_bit_i,
  output logic            tx_bit_o,
  output logic            code_32_o,
  output logic            double_rate_o,
  output logic            oversample_12_o,
  output logic            dual_code_o,
  output logic            split_code_o,
  output logic            byte_mode_o,
  input  wire logic       serial_data_pin_i,
  input  wire logic       serial_data_valid_pin_i,
  output logic            serial_rx_data_o,
  output logic            serial_rx_valid_o,
  output logic            irq_o,
  output logic            irq_oe_o
);

  ////////////////////////////////////////////////////////////////////////
  // control registers
  logic [7:0] rate_q;
  logic [7:0] cfg_q;
  logic [7:0] frame_q;
  logic [7:0] rxen_q;

  // reserved bits are dropped on write so they always read zero
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rate_q  <= `BSRX_RST_RATE;
      cfg_q   <= `BSRX_RST_CFG;
      frame_q <= `BSRX_RST_FRAME;
      rxen_q  <= `BSRX_RST_RXEN;
    end else if (wr_i) begin
      if (addr_i == `BSRX_ADDR_RATE) begin
        rate_q <= wdata_i & `BSRX_MASK_RATE;
      end else if (addr_i == `BSRX_ADDR_CFG) begin
        cfg_q <= wdata_i & `BSRX_MASK_CFG;
      end else if (addr_i == `BSRX_ADDR_FRAME) begin
        frame_q <= wdata_i & `BSRX_MASK_FRAME;
      end else if (addr_i == `BSRX_ADDR_RXEN) begin
        rxen_q <= wdata_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // rate decode; patterns without the code width bit give 64-chip, double rate wins over 12x
  bsrx_mode_type mode;
  always_comb begin
    if (!rate_q[`BSRX_BIT_CODEW]) begin
      mode = BSRX_MODE_64;
    end else if (rate_q[`BSRX_BIT_DRATE]) begin
      mode = BSRX_MODE_32DDR;
    end else begin
      mode = BSRX_MODE_32NRM;
    end
  end

  assign code_32_o       = (mode != BSRX_MODE_64);
  assign double_rate_o   = (mode == BSRX_MODE_32DDR);
  assign split_code_o    = double_rate_o;
  // 12x only honoured at normal 32-chip rate, and it costs the second code
  assign oversample_12_o = (mode == BSRX_MODE_32NRM) && rate_q[`BSRX_BIT_SRATE];
  assign dual_code_o     = (mode == BSRX_MODE_32NRM) && !rate_q[`BSRX_BIT_SRATE];
  assign byte_mode_o     = frame_q[`BSRX_BIT_SERDES];

  ////////////////////////////////////////////////////////////////////////
  // data inversion
  logic [1:0] rx_bit;
  assign rx_bit   = bit_data_i ^ {2{cfg_q[`BSRX_BIT_RXINV]}};
  assign tx_bit_o = tx_bit_i ^ cfg_q[`BSRX_BIT_TXINV];

  ////////////////////////////////////////////////////////////////////////
  // bit-serial pins pass a two-flop synchroniser whose output drives nothing
  logic [1:0] pin_meta_q;
  logic [1:0] pin_sync_q;
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_meta_q <= 2'h0;
      pin_sync_q <= 2'h0;
    end else begin
      pin_meta_q <= {serial_data_valid_pin_i, serial_data_pin_i};
      pin_sync_q <= pin_meta_q;
    end
  end
  // bit-serial path stays quiet in byte mode
  assign serial_rx_valid_o = !byte_mode_o && rx_enable_i && bit_valid_i[0] && bit_tick_i;
  assign serial_rx_data_o  = rx_bit[0];

  ////////////////////////////////////////////////////////////////////////
  // per-channel byte assembly, end of frame and status
  logic [7:0] data_q  [2];
  logic [7:0] valid_q [2];
  logic [3:0] stat_q  [2];
  logic [1:0] rd_data;

  assign rd_data[0] = rd_i && (addr_i == `BSRX_ADDR_DATA_A);
  assign rd_data[1] = rd_i && (addr_i == `BSRX_ADDR_DATA_B);

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_chan
      logic [7:0] sh_q;
      logic [2:0] cnt_q;
      logic [2:0] gap_q;
      logic       started_q;
      logic       filled_q;
      logic       vbit;
      logic       byte_done;
      logic       eof;
      logic       load;
      logic       stat_rd;

      assign vbit      = byte_mode_o && rx_enable_i && bit_tick_i && bit_valid_i[ch];
      assign byte_done = vbit && (cnt_q == 3'h7);
      // gap counter reaching the length ends the frame; zero ends at first gap
      assign eof       = byte_mode_o && rx_enable_i && bit_tick_i && !bit_valid_i[ch]
                         && started_q && (gap_q == frame_q[2:0]);
      assign load      = byte_done || (eof && cnt_q != 3'h0);
      assign stat_rd   = rd_i && (addr_i == `BSRX_ADDR_RXSTAT);

      // shift in lsb first, count gaps between valid bits
      always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
          sh_q      <= 8'h00;
          cnt_q     <= 3'h0;
          gap_q     <= 3'h0;
          started_q <= 1'b0;
        end else if (!rx_enable_i || !byte_mode_o) begin
          cnt_q     <= 3'h0;
          gap_q     <= 3'h0;
          started_q <= 1'b0;
        end else if (vbit) begin
          sh_q[cnt_q] <= rx_bit[ch];
          cnt_q       <= cnt_q + 3'h1;
          gap_q       <= 3'h0;
          started_q   <= 1'b1;
        end else if (eof) begin
          cnt_q     <= 3'h0;
          gap_q     <= 3'h0;
          started_q <= 1'b0;
        end else if (bit_tick_i && started_q) begin
          gap_q <= gap_q + 3'h1;
        end
      end

      // data register takes the byte or partial frame
      always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
          data_q[ch]  <= 8'h00;
          valid_q[ch] <= 8'h00;
          filled_q    <= 1'b0;
        end else if (load) begin
          data_q[ch]  <= byte_done ? {rx_bit[ch], sh_q[6:0]} : sh_q;
          valid_q[ch] <= byte_done ? 8'hFF : (8'hFF >> (4'h8 - {1'b0, cnt_q}));
          filled_q    <= 1'b1;
        end else if (rd_data[ch]) begin
          filled_q <= 1'b0;
        end
      end

      // sticky status; a new event wins over the clear by status read
      always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
          stat_q[ch] <= 4'h0;
        end else begin
          stat_q[ch][`BSRX_ST_FULL]  <= load || (stat_q[ch][`BSRX_ST_FULL] && !stat_rd);
          stat_q[ch][`BSRX_ST_EOF]   <= eof || (stat_q[ch][`BSRX_ST_EOF] && !stat_rd);
          stat_q[ch][`BSRX_ST_FLOW]  <= (load && filled_q)
                                        || (rd_data[ch] && !filled_q)
                                        || (stat_q[ch][`BSRX_ST_FLOW] && !stat_rd);
          stat_q[ch][`BSRX_ST_VALID] <= load ? byte_done
                                        : (stat_q[ch][`BSRX_ST_VALID] && !rd_data[ch]);
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // status view; hidden outside receive mode
  logic [7:0] stat_view;
  logic [7:0] flow_en;
  assign stat_view = rx_enable_i ? {stat_q[1], stat_q[0]} : 8'h00;
  // flow bit covers two enables, underflow and overflow, per channel
  assign flow_en = {1'b0, rxen_q[7] | rxen_q[6], rxen_q[5:4],
                    1'b0, rxen_q[`BSRX_EN_UFLOW] | rxen_q[2], rxen_q[1:0]};

  ////////////////////////////////////////////////////////////////////////
  // interrupt pin with selectable drive
  logic irq_active;
  bsrx_irq_drive_type drive;
  assign irq_active = |(stat_view & flow_en);
  assign drive      = bsrx_irq_drive_type'(cfg_q[1:0]);

  always_comb begin
    case (drive)
      BSRX_IRQ_OPEN_DRN: begin
        irq_o    = 1'b0;
        irq_oe_o = irq_active;
      end
      BSRX_IRQ_OPEN_SRC: begin
        irq_o    = 1'b1;
        irq_oe_o = irq_active;
      end
      BSRX_IRQ_CMOS_HIGH: begin
        irq_o    = irq_active;
        irq_oe_o = 1'b1;
      end
      default: begin
        irq_o    = !irq_active;
        irq_oe_o = 1'b1;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // read data, one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      if (addr_i == `BSRX_ADDR_RATE) begin
        rdata_o <= rate_q;
      end else if (addr_i == `BSRX_ADDR_CFG) begin
        rdata_o <= cfg_q;
      end else if (addr_i == `BSRX_ADDR_FRAME) begin
        rdata_o <= frame_q;
      end else if (addr_i == `BSRX_ADDR_RXEN) begin
        rdata_o <= rxen_q;
      end else if (addr_i == `BSRX_ADDR_RXSTAT) begin
        rdata_o <= stat_view;
      end else if (addr_i == `BSRX_ADDR_DATA_A) begin
        rdata_o <= data_q[0];
      end else if (addr_i == `BSRX_ADDR_VALID_A) begin
        rdata_o <= valid_q[0];
      end else if (addr_i == `BSRX_ADDR_DATA_B) begin
        rdata_o <= data_q[1];
      end else if (addr_i == `BSRX_ADDR_VALID_B) begin
        rdata_o <= valid_q[1];
      end else begin
        rdata_o <= 8'h00;
      end
    end
  end

endmodule : bsrx_config

// *** design/bsrx_defines.svh ***
`ifndef BSRX_DEFINES_SVH
`define BSRX_DEFINES_SVH
`define BSRX_ADDR_RATE     6'h04
`define BSRX_ADDR_CFG      6'h05
`define BSRX_ADDR_FRAME    6'h06
`define BSRX_ADDR_RXEN     6'h07
`define BSRX_ADDR_RXSTAT   6'h08
`define BSRX_ADDR_DATA_A   6'h09
`define BSRX_ADDR_VALID_A  6'h0A
`define BSRX_ADDR_DATA_B   6'h0B
`define BSRX_ADDR_VALID_B  6'h0C
`define BSRX_RST_RATE      8'h00
`define BSRX_RST_CFG       8'h01
`define BSRX_RST_FRAME     8'h03
`define BSRX_RST_RXEN      8'h00
`define BSRX_MASK_RATE     8'h07
`define BSRX_MASK_CFG      8'h1B
`define BSRX_MASK_FRAME    8'h0F
`define BSRX_BIT_CODEW     2
`define BSRX_BIT_DRATE     1
`define BSRX_BIT_SRATE     0
`define BSRX_BIT_RXINV     4
`define BSRX_BIT_TXINV     3
`define BSRX_BIT_SERDES    3
`define BSRX_ST_FULL       0
`define BSRX_ST_EOF        1
`define BSRX_ST_FLOW       2
`define BSRX_ST_VALID      3
`define BSRX_EN_UFLOW      3
`endif

// *** design/bsrx_pkg.sv ***
package bsrx_pkg;
  typedef enum logic [1:0] {
    BSRX_IRQ_CMOS_LOW  = 2'h0,
    BSRX_IRQ_CMOS_HIGH = 2'h1,
    BSRX_IRQ_OPEN_SRC  = 2'h2,
    BSRX_IRQ_OPEN_DRN  = 2'h3
  } bsrx_irq_drive_type;
  typedef enum logic [2:0] {
    BSRX_MODE_64    = 3'h1,
    BSRX_MODE_32DDR = 3'h2,
    BSRX_MODE_32NRM = 3'h4
  } bsrx_mode_type;
endpackage : bsrx_pkg

// *** verif/baseband_serdes_config_rx_irq_tb.sv ***
module baseband_serdes_config_rx_irq_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import bsrx_pkg::*;
  typedef struct packed { logic [7:0] rate; logic [4:0] exp; } bsrx_row_type;
  logic clk_sys_i = 1'b0, rstn_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, rx_en = 1'b0;
  logic tx_bit_i = 1'b0, go = 1'b0, busy, tick, tx_o, c32, ddr, o12, dual, split, bym;
  logic srx_d, srx_v, irq_o, irq_oe_o;
  logic [5:0] addr_i = 6'h00;
  logic [7:0] wdata_i = 8'h00, sdat = 8'h00, rdata_o;
  logic [3:0] nbits = 4'h0;
  logic [1:0] bval, bdat;
  int num_errors = 0, checks_done = 0, cyc = 0;
  logic [7:0] ser_bits = 8'h00, ser_cnt = 8'h00;
  bsrx_row_type rows [5] = '{'{8'h00, 5'h00}, '{8'h04, 5'h12}, '{8'h05, 5'h14},
    '{8'h06, 5'h19}, '{8'h07, 5'h19}};
  always #5 clk_sys_i = ~clk_sys_i;
  bsrx_radio_model radio (.clk_sys_i, .rstn_i, .go_i(go), .nbits_i(nbits), .data_i(sdat),
    .busy_o(busy), .bit_tick_o(tick), .bit_valid_o(bval), .bit_data_o(bdat));
  bsrx_config dut (.clk_sys_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .rx_enable_i(rx_en), .bit_valid_i(bval), .bit_data_i(bdat), .bit_tick_i(tick),
    .tx_bit_i, .tx_bit_o(tx_o), .code_32_o(c32), .double_rate_o(ddr), .oversample_12_o(o12),
    .dual_code_o(dual), .split_code_o(split), .byte_mode_o(bym), .serial_data_pin_i(1'b0),
    .serial_data_valid_pin_i(1'b0), .serial_rx_data_o(srx_d), .serial_rx_valid_o(srx_v),
    .irq_o, .irq_oe_o);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk_byte
  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
    // let the new register value settle before anyone looks at outputs
    #1;
  endtask : wr
  // read data appear in the cycle after the strobe and hold until the next read, so sample there
  task automatic rd(input string n, input logic [5:0] a, input logic [7:0] m, e);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 chk_byte(n, e, rdata_o & m);
  endtask : rd
  // hand a frame to the radio, wait for it, then let the gap run out
  task automatic send(input logic [3:0] n, input logic [7:0] v);
    @(posedge clk_sys_i);
    go <= 1'b1;
    nbits <= n;
    sdat <= v;
    @(posedge clk_sys_i);
    go <= 1'b0;
    for (int i = 0; i < 100 && busy; i++) @(posedge clk_sys_i);
    repeat (40) @(posedge clk_sys_i);
  endtask : send
  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run
  // collect the bit-serial output, newest bit at the bottom
  always @(posedge clk_sys_i) begin
    if (srx_v) begin
      ser_bits <= {ser_bits[6:0], srx_d};
      ser_cnt  <= ser_cnt + 8'h01;
    end
  end
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      complete_run();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    foreach (rows[i]) begin
      wr(6'h04, rows[i].rate);
      rd("rate", 6'h04, 8'hFF, rows[i].rate);
      chk_byte("modes", {3'h0, rows[i].exp}, {3'h0, c32, ddr, o12, dual, split});
    end
    rd("cfg rst", 6'h05, 8'hFF, 8'h01);
    rd("frame rst", 6'h06, 8'hFF, 8'h03);
    rd("en rst", 6'h07, 8'hFF, 8'h00);
    rd("unmapped", 6'h3E, 8'hFF, 8'h00);
    wr(6'h05, 8'hFF);
    rd("cfg mask", 6'h05, 8'hFF, 8'h1B);
    tx_bit_i <= 1'b1;
    wr(6'h05, 8'h09);
    chk_byte("tx inv", 8'h00, {7'h0, tx_o});
    rx_en <= 1'b1;
    send(4'h2, 8'h03);
    chk_byte("serial count", 8'h02, ser_cnt);
    chk_byte("serial bits", 8'h03, ser_bits);
    rx_en <= 1'b0;
    wr(6'h06, 8'h08);
    wr(6'h07, 8'h11);
    rx_en <= 1'b1;
    send(4'h8, 8'hA5);
    chk_byte("irq full", 8'h01, {7'h0, irq_o});
    rd("full", 6'h08, 8'h11, 8'h11);
    rd("data", 6'h09, 8'hFF, 8'hA5);
    rd("valid", 6'h0A, 8'hFF, 8'hFF);
    // partial frames: length 0 ends at the first idle bit time
    for (int k = 0; k < 2; k++) begin
      wr(6'h06, k ? 8'h0A : 8'h08);
      wr(6'h07, 8'h02);
      send(k ? 4'h3 : 4'h1, k ? 8'h05 : 8'h01);
      chk_byte("irq eof", 8'h01, {7'h0, irq_o});
      rd("eof", 6'h08, 8'h02, 8'h02);
      rd("part", 6'h09, k ? 8'h07 : 8'h01, k ? 8'h05 : 8'h01);
    end
    wr(6'h05, 8'h11);
    wr(6'h07, 8'h04);
    send(4'h8, 8'h3C);
    rd("rx inv", 6'h09, 8'hFF, 8'hC3);
    send(4'h8, 8'h0F);
    send(4'h8, 8'h0F);
    chk_byte("irq ovf", 8'h01, {7'h0, irq_o});
    rd("ovf", 6'h08, 8'h04, 8'h04);
    wr(6'h07, 8'h08);
    rd("data", 6'h09, 8'hFF, 8'hF0);
    rd("empty", 6'h09, 8'h00, 8'h00);
    rd("unf", 6'h08, 8'h04, 8'h04);
    rd("empty", 6'h09, 8'h00, 8'h00);
    for (int m = 0; m < 4; m++) begin
      wr(6'h05, 8'(m));
      chk_byte("pin", {6'h0, m == 1 || m == 2, 1'b1}, {6'h0, irq_o, irq_oe_o});
    end
    wr(6'h07, 8'h00);
    chk_byte("pin off", 8'h00, {7'h0, irq_oe_o});
    rx_en <= 1'b0;
    rd("rx off", 6'h08, 8'hFF, 8'h00);
    complete_run();
  end
endmodule : baseband_serdes_config_rx_irq_tb

// *** verif/bsrx_props.sv ***
module bsrx_props (
  input wire logic       clk_sys_i,
  input wire logic       rstn_i,
  input wire logic [5:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic       rx_enable_i,
  input wire logic [1:0] bit_valid_i,
  input wire logic       bit_tick_i,
  input wire logic       tx_bit_i,
  input wire logic       tx_bit_o,
  input wire logic       code_32_o,
  input wire logic       double_rate_o,
  input wire logic       oversample_12_o,
  input wire logic       dual_code_o,
  input wire logic       split_code_o,
  input wire logic       byte_mode_o,
  input wire logic       serial_rx_valid_o,
  input wire logic       irq_o,
  input wire logic       irq_oe_o
);
  logic [7:0] rate_q, cfg_q, frm_q, en_q;
  // shadow of the writable registers, reserved bits dropped as the design does
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rate_q <= 8'h00;
      cfg_q <= 8'h01;
      frm_q <= 8'h03;
      en_q <= 8'h00;
    end else if (wr_i) begin
      if (addr_i == 6'h04) rate_q <= wdata_i & 8'h07;
      if (addr_i == 6'h05) cfg_q <= wdata_i & 8'h1B;
      if (addr_i == 6'h06) frm_q <= wdata_i & 8'h0F;
      if (addr_i == 6'h07) en_q <= wdata_i;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  a_code_width: assert property (code_32_o == rate_q[2]) else $error("code width");
  a_double_rate: assert property (double_rate_o == (rate_q[2] && rate_q[1]))
    else $error("double rate");
  a_split_code: assert property (split_code_o == double_rate_o) else $error("split");
  a_dual_code: assert property (dual_code_o == (rate_q[2:0] == 3'h4)) else $error("dual");
  a_over_sample: assert property (oversample_12_o == (rate_q[2:0] == 3'h5))
    else $error("oversample");
  a_tx_invert: assert property (tx_bit_o == (tx_bit_i ^ cfg_q[3])) else $error("tx inv");
  a_open_level: assert property (cfg_q[1] |-> irq_o == !cfg_q[0]) else $error("open");
  a_cmos_drive: assert property (!cfg_q[1] |-> irq_oe_o) else $error("cmos oe");
  a_irq_quiet: assert property (en_q == 8'h00 |-> irq_o == !cfg_q[0] && irq_oe_o == !cfg_q[1])
    else $error("irq idle");
  a_byte_mode: assert property (byte_mode_o == frm_q[3]) else $error("byte mode");
  a_serial_valid: assert property (serial_rx_valid_o ==
    (!frm_q[3] && rx_enable_i && bit_valid_i[0] && bit_tick_i)) else $error("serial valid");
  a_rx_off_zero: assert property (rd_i && addr_i == 6'h08 && !rx_enable_i |=>
    rdata_o == 8'h00) else $error("status when off");
  cover property (double_rate_o);
  cover property (irq_o && irq_oe_o && cfg_q[1:0] == 2'h1);
  cover property (serial_rx_valid_o);
endmodule : bsrx_props

bind bsrx_config bsrx_props u_props (.clk_sys_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .rd_i,
  .rdata_o, .rx_enable_i, .bit_valid_i, .bit_tick_i, .tx_bit_i, .tx_bit_o, .code_32_o,
  .double_rate_o, .oversample_12_o, .dual_code_o, .split_code_o, .byte_mode_o,
  .serial_rx_valid_o, .irq_o, .irq_oe_o);

// *** verif/bsrx_radio_model.sv ***
module bsrx_radio_model (
  input  wire logic       clk_sys_i,
  input  wire logic       rstn_i,
  input  wire logic       go_i,
  input  wire logic [3:0] nbits_i,
  input  wire logic [7:0] data_i,
  output logic            busy_o,
  output logic            bit_tick_o,
  output logic [1:0]      bit_valid_o,
  output logic [1:0]      bit_data_o
);
  logic [1:0] div_q;
  logic [3:0] left_q;
  logic [7:0] sh_q;
  logic       last_q;
  // bit time of four clocks, free running like the radio divider
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) div_q <= 2'h0;
    else div_q <= div_q + 2'h1;
  end
  assign bit_tick_o = (div_q == 2'h3);
  // bits leave lsb first, one per tick, same bits on both channels
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      left_q <= 4'h0;
      sh_q <= 8'h00;
      last_q <= 1'b0;
    end else if (go_i) begin
      left_q <= nbits_i;
      sh_q <= data_i;
    end else if (bit_tick_o && busy_o) begin
      left_q <= left_q - 4'h1;
      sh_q <= sh_q >> 1;
      last_q <= sh_q[0];
    end
  end
  assign busy_o = (left_q != 4'h0);
  assign bit_valid_o = {2{busy_o}};
  // idle data flips against the last bit so a stale value never looks valid
  assign bit_data_o = busy_o ? {2{sh_q[0]}} : {2{~last_q}};
endmodule : bsrx_radio_model
